// >>> bench/csms_checker_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------
// Port checks of the clock select block
// ------------------------------------------
module csms_checker_asserts
  import csms_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic main_clock_ready_in,
  input wire logic sub_clock_ready_in,
  input wire csms_pin_mode_t main_pin_mode_out,
  input wire logic config_locked_out,
  input wire logic cpu_clock_source_select_out,
  input wire logic cpu_clock_source_status_out,
  input wire logic main_clock_source_select_out,
  input wire logic main_clock_source_status_out
);
  logic [7:0] sub_run;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Run length of sub ready, saturating so it never wraps
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !sub_clock_ready_in)
      sub_run <= 8'h00;
    else if (sub_run != 8'hff)
      sub_run <= sub_run + 8'h01;
  end

  // Short names for the watched lock and switch ports
  wire logic locked = config_locked_out;
  wire logic cpu_st = cpu_clock_source_status_out;
  wire logic cpu_sel = cpu_clock_source_select_out;
  wire logic main_st = main_clock_source_status_out;
  wire logic main_sel = main_clock_source_select_out;

  sequence s_first_access;
    psel_in && penable_in && !$past(penable_in);
  endsequence
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  sequence s_sel_read;
    pready_out && !pwrite_in && paddr_in == SELECT_ADDR;
  endsequence
  sequence s_cfg_read;
    pready_out && !pwrite_in && paddr_in == CONFIG_ADDR;
  endsequence

  a_one_wait_state: assert property (s_first_access |-> s_answer)
    else $error("answer not after one wait state");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_error_in_access: assert property (pslverr_out |-> pready_out && penable_in)
    else $error("error outside access");
  a_select_low_zero: assert property (s_sel_read |-> prdata_out[3:0] == 4'h0)
    else $error("select low bits not zero");
  a_config_bit_zero: assert property (s_cfg_read |-> (prdata_out & 32'hffff_ff08) == '0)
    else $error("config read has stray bits");
  a_lock_holds: assert property (locked |=> locked)
    else $error("lock dropped");
  a_mode_frozen: assert property ($past(locked, 2) |-> $stable(main_pin_mode_out))
    else $error("pin mode changed after lock");
  a_cpu_status_follows: assert property ($changed(cpu_st) |-> cpu_st == $past(cpu_sel))
    else $error("cpu status moved away from select");
  a_cpu_needs_sub: assert property ($rose(cpu_st) |-> $past(sub_run)+1 >= SETTLE_CYCLES)
    else $error("cpu status rose before sub ready");
  a_main_status_follows: assert property ($changed(main_st) |-> main_st == $past(main_sel))
    else $error("main status moved away from select");
  a_main_needs_ready: assert property ($rose(main_st) |-> $past(main_clock_ready_in))
    else $error("main status rose before ready");
endmodule

bind csms_clock_source_mode_select csms_checker_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
  .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .pslverr_out, .main_clock_ready_in, .sub_clock_ready_in,
  .main_pin_mode_out, .config_locked_out, .cpu_clock_source_select_out,
  .cpu_clock_source_status_out, .main_clock_source_select_out,
  .main_clock_source_status_out
);

// >>> bench/csms_clock_source_mode_select_bench.sv
`timescale 1ns/100ps
// ------------------------------------------
// Bench of the clock select block
// ------------------------------------------
module csms_clock_source_mode_select_bench;
  import csms_pkg::*;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [19:0] paddr_in = 20'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'h1;
  logic main_on = 1'h0;
  logic sub_on = 1'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic main_ready;
  logic sub_ready;
  csms_pin_mode_t main_mode;
  csms_pin_mode_t sub_mode;
  csms_drive_t drive;
  logic gain;
  logic locked;
  logic cpu_sel;
  logic cpu_st;
  logic main_sel;
  logic main_st;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] cfg_vals [4] = '{8'h00, 8'hf4, 8'ha6, 8'h53};

  always #5 clk_in = ~clk_in;

  // Short settle count keeps the switch checks quick
  csms_clock_source_mode_select #(.SETTLE_CYCLES(1)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .main_clock_ready_in(main_ready), .sub_clock_ready_in(sub_ready),
    .main_pin_mode_out(main_mode), .sub_pin_mode_out(sub_mode), .sub_drive_mode_out(drive),
    .main_oscillator_high_gain_out(gain), .config_locked_out(locked),
    .cpu_clock_source_select_out(cpu_sel), .cpu_clock_source_status_out(cpu_st),
    .main_clock_source_select_out(main_sel), .main_clock_source_status_out(main_st)
  );

  csms_clock_sources i_src (
    .clk_in(clk_in), .main_enable_in(main_on), .sub_enable_in(sub_on),
    .main_ready_out(main_ready), .sub_ready_out(sub_ready)
  );

  task results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, far above the length of the run
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      mismatches++;
    end
  endtask

  // Answer is taken at the rising edge where ready is seen high; the request
  // stands until then, and only the hang guard ends a wait
  task apb(input logic wr, input logic [19:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'h1);
    rd = prdata_out;
    err = pslverr_out;
    chk(32'(n), 32'h2, "one wait state");
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask

  task rd_chk(input logic [19:0] a, input logic [7:0] exp, input string what);
    apb(1'h0, a, 8'h00, 4'h1);
    chk(rd, {24'h0, exp}, what);
    chk(32'(err), 32'h0, what);
  endtask

  task poll(input logic [19:0] a, input logic [7:0] exp, input string what);
    int k;
    k = 0;
    do
    begin
      apb(1'h0, a, 8'h00, 4'h1);
      k++;
    end while (rd !== {24'h0, exp} && k < 20);
    chk(rd, {24'h0, exp}, what);
  endtask

  task rst;
    rst_n_in <= 1'h0;
    main_on <= 1'h0;
    sub_on <= 1'h0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'h1;
  endtask

  function automatic logic [1:0] want_mode(input logic ext, input logic osc);
    if (!osc)
      return CSMS_PIN_INPUT_PORT;
    return ext ? CSMS_PIN_EXTERNAL_CLOCK : CSMS_PIN_OSCILLATOR;
  endfunction

  task t_reset;
    rd_chk(CONFIG_ADDR, 8'h00, "config reset");
    rd_chk(SELECT_ADDR, 8'h00, "select reset");
    chk(32'({locked, cpu_sel, cpu_st, main_sel, main_st}), 32'h0, "ports at reset");
  endtask

  // One write per reset; a bad strobe must not use it up
  task t_config(input logic [7:0] v);
    rst();
    apb(1'h1, CONFIG_ADDR, v, 4'h3);
    chk(32'(err), 32'h1, "wide write refused");
    rd_chk(CONFIG_ADDR, 8'h00, "wide write dropped");
    apb(1'h1, CONFIG_ADDR, v, 4'h1);
    apb(1'h1, CONFIG_ADDR, ~v & 8'hf7, 4'h1);
    rd_chk(CONFIG_ADDR, v, "late write ignored");
    rd_chk(STATUS_ADDR, (v[2:1] == 2'h3) ? 8'h0b : 8'h03, "lock status");
    chk(32'(main_mode), 32'(want_mode(v[7], v[6])), "main pin mode");
    chk(32'(sub_mode), 32'(want_mode(v[5], v[4])), "sub pin mode");
    chk(32'(drive), 32'(v[2:1]), "sub drive");
    chk(32'({gain, locked}), {30'h0, v[0], 1'h1}, "gain and lock");
  endtask

  // Sources start only after the pins are set up
  task t_select;
    apb(1'h1, SELECT_ADDR, 8'h10, 4'h1);
    rd_chk(SELECT_ADDR, 8'h10, "main status waits");
    rd_chk(STATUS_ADDR, 8'h07, "switch busy");
    apb(1'h1, STATUS_ADDR, 8'h02, 4'h1);
    rd_chk(STATUS_ADDR, 8'h05, "late flag cleared");
    main_on <= 1'h1;
    poll(SELECT_ADDR, 8'h30, "main external");
    apb(1'h1, SELECT_ADDR, 8'hff, 4'h1);
    rd_chk(SELECT_ADDR, 8'h70, "status read-only");
    sub_on <= 1'h1;
    poll(SELECT_ADDR, 8'hf0, "cpu on sub");
    chk(32'({cpu_sel, cpu_st, main_sel, main_st}), 32'hf, "select ports");
    apb(1'h1, SELECT_ADDR, 8'h10, 4'h1);
    poll(SELECT_ADDR, 8'h30, "cpu on main");
    apb(1'h1, SELECT_ADDR, 8'h00, 4'h1);
    poll(SELECT_ADDR, 8'h00, "main internal");
  endtask

  task t_unmapped;
    apb(1'h0, 20'hfffac, 8'h00, 4'h1);
    chk({rd[31:1], err}, 32'h1, "unmapped read");
    apb(1'h1, 20'hfffac, 8'hff, 4'h1);
    chk(32'(err), 32'h1, "unmapped write");
  endtask

  initial
  begin
    rst();
    t_reset();
    foreach (cfg_vals[i])
      t_config(cfg_vals[i]);
    t_select();
    t_unmapped();
    results();
  end
endmodule

// >>> bench/csms_clock_sources.sv
`timescale 1ns/100ps
// ------------------------------------------
// Resonators on the main and sub pins
// ------------------------------------------
module csms_clock_sources #(
  parameter int unsigned START_CYCLES = 3
) (
  input wire logic clk_in,
  input wire logic main_enable_in,
  input wire logic sub_enable_in,
  output logic main_ready_out,
  output logic sub_ready_out
);
  int main_cnt = 0;
  int sub_cnt = 0;

  // Ready only once started; a stopped source drops ready at the next clock edge
  always @(posedge clk_in)
  begin
    main_cnt <= main_enable_in ? main_cnt + 1 : 0;
    sub_cnt <= sub_enable_in ? sub_cnt + 1 : 0;
  end

  assign main_ready_out = (main_cnt >= START_CYCLES);
  assign sub_ready_out = (sub_cnt >= START_CYCLES);
endmodule

// >>> verilog/csms_cfg_if.sv
`timescale 1ns/100ps
interface csms_cfg_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  logic locked;
  logic late_write;

  modport owner(input wr_en, input wr_data, output value, output locked, output late_write);
  modport user(output wr_en, output wr_data, input value, input locked, input late_write);
endinterface

// >>> verilog/csms_clock_source_mode_select.sv
// Behaviour
// - Pin-mode config takes only first write
// - Pin-mode config readable at any time
// - Reset zeros config and re-arms write
// - Main pin bits decode to pin mode
// - Sub pin bits decode to pin mode
// - Sub drive field selects power level
// - Clock select resets zero, bit access
// - CPU status shows main or sub source
// - CPU select requests main or sub clock
// - Main status shows internal or external source
// - Main select chooses internal or external source
// - Status bits read-only, low bits zero
`timescale 1ns/100ps
module csms_clock_source_mode_select #(
  parameter int unsigned SETTLE_CYCLES = csms_pkg::SWITCH_SETTLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [csms_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic main_clock_ready_in,
  input wire logic sub_clock_ready_in,
  output csms_pkg::csms_pin_mode_t main_pin_mode_out,
  output csms_pkg::csms_pin_mode_t sub_pin_mode_out,
  output csms_pkg::csms_drive_t sub_drive_mode_out,
  output logic main_oscillator_high_gain_out,
  output logic config_locked_out,
  output logic cpu_clock_source_select_out,
  output logic cpu_clock_source_status_out,
  output logic main_clock_source_select_out,
  output logic main_clock_source_status_out
);
  import csms_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rd_data;
    logic ack;
    logic err;
    logic cpu_select;
    logic main_select;
    logic late_write;
    csms_pin_mode_t main_mode;
    csms_pin_mode_t sub_mode;
    csms_drive_t drive;
    logic gain;
  } csms_top_state_t;

  localparam csms_top_state_t TOP_RESET = '{
    rd_data: 32'h0000_0000,
    ack: 1'b0,
    err: 1'b0,
    cpu_select: SELECT_RESET[SEL_CPU_SELECT_BIT],
    main_select: SELECT_RESET[SEL_MAIN_SELECT_BIT],
    late_write: 1'b0,
    main_mode: CSMS_PIN_INPUT_PORT,
    sub_mode: CSMS_PIN_INPUT_PORT,
    drive: CSMS_DRIVE_LOW_POWER,
    gain: 1'b0
  };

  csms_top_state_t st;
  csms_top_state_t next_st;

  // ----------------------------------------------------------------
  // Internal wiring
  // ----------------------------------------------------------------
  csms_cfg_if cfg ();

  logic access;
  logic complete;
  logic hit_config;
  logic hit_select;
  logic hit_status;
  logic lane0;
  logic cfg_write_ok;
  logic cpu_status;
  logic cpu_busy;
  logic main_status;
  logic main_busy;
  logic cpu_target_ready;
  logic main_target_ready;
  logic [7:0] config_view;
  logic [7:0] select_view;
  logic [7:0] status_view;
  logic [7:0] read_byte;
  logic read_err;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state: read data is captured in the first access cycle so that
  // prdata comes straight from a flop rather than from the decode mux
  assign access = psel_in && penable_in;
  assign complete = access && st.ack;
  assign hit_config = paddr_in == CONFIG_ADDR;
  assign hit_select = paddr_in == SELECT_ADDR;
  assign hit_status = paddr_in == STATUS_ADDR;
  assign lane0 = pstrb_in[0];

  // The config only takes a whole single-byte write; wider or narrower strobes
  // are refused so a stray word store cannot burn the one write
  assign cfg_write_ok = pstrb_in == BYTE_LANE_ONLY;

  // ----------------------------------------------------------------
  // Write-once pin-mode configuration
  // ----------------------------------------------------------------
  assign cfg.wr_en = complete && pwrite_in && hit_config && cfg_write_ok;
  assign cfg.wr_data = pwdata_in[7:0];

  csms_config_once u_config (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg(cfg.owner)
  );

  // ----------------------------------------------------------------
  // Clock switch trackers
  // ----------------------------------------------------------------
  // Going back to the main clock needs nothing from outside; going to the sub
  // clock waits until the sub source reports ready
  assign cpu_target_ready = st.cpu_select ? sub_clock_ready_in : 1'b1;

  // The internal oscillator is assumed always running while selectable
  assign main_target_ready = st.main_select ? main_clock_ready_in : 1'b1;

  csms_switch_tracker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_cpu_switch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .select_in(st.cpu_select),
    .source_ready_in(cpu_target_ready),
    .status_out(cpu_status),
    .busy_out(cpu_busy)
  );

  csms_switch_tracker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_main_switch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .select_in(st.main_select),
    .source_ready_in(main_target_ready),
    .status_out(main_status),
    .busy_out(main_busy)
  );

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Config reads back whatever is held, locked or not
  assign config_view = cfg.value;

  // Select register: status in 7 and 5, selects in 6 and 4, low nibble zero
  always_comb
  begin
    select_view = 8'h00;
    select_view[SEL_CPU_STATUS_BIT] = cpu_status;
    select_view[SEL_CPU_SELECT_BIT] = st.cpu_select;
    select_view[SEL_MAIN_STATUS_BIT] = main_status;
    select_view[SEL_MAIN_SELECT_BIT] = st.main_select;
  end

  // Block status: lock, stray write seen, switch in progress, bad drive code
  always_comb
  begin
    status_view = 8'h00;
    status_view[ST_LOCKED_BIT] = cfg.locked;
    status_view[ST_LATE_WRITE_BIT] = st.late_write;
    status_view[ST_BUSY_BIT] = cpu_busy || main_busy;
    status_view[ST_DRIVE_BAD_BIT] = st.drive == CSMS_DRIVE_PROHIBITED;
  end

  // Read mux and error decode for the captured answer
  always_comb
  begin
    read_byte = 8'h00;
    read_err = 1'b0;
    if (hit_config)
    begin
      read_byte = config_view;
      read_err = pwrite_in && !cfg_write_ok;
    end
    else if (hit_select)
      read_byte = select_view;
    else if (hit_status)
      read_byte = status_view;
    else
      read_err = 1'b1;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    // Handshake: ready rises in the second access cycle and drops after it
    next_st.ack = access && !st.ack;
    if (access && !st.ack)
    begin
      next_st.rd_data = {24'h00_0000, pwrite_in ? 8'h00 : read_byte};
      next_st.err = read_err;
    end
    else if (!access)
    begin
      next_st.rd_data = 32'h0000_0000;
      next_st.err = 1'b0;
    end

    // Clock select: bit stores are byte stores on lane 0; only 6 and 4 land
    if (complete && pwrite_in && hit_select && lane0)
    begin
      next_st.cpu_select = pwdata_in[SEL_CPU_SELECT_BIT];
      next_st.main_select = pwdata_in[SEL_MAIN_SELECT_BIT];
    end

    // Sticky stray-write flag: write 1 clears, a new stray write wins
    if (complete && pwrite_in && hit_status && lane0 && pwdata_in[ST_LATE_WRITE_BIT])
      next_st.late_write = 1'b0;
    if (cfg.late_write)
      next_st.late_write = 1'b1;

    // Registered decode of the pin configuration
    next_st.main_mode = csms_decode_pin_mode(cfg.value[CFG_MAIN_EXT_BIT],
                                             cfg.value[CFG_MAIN_OSC_BIT]);
    next_st.sub_mode = csms_decode_pin_mode(cfg.value[CFG_SUB_EXT_BIT],
                                            cfg.value[CFG_SUB_OSC_BIT]);
    next_st.drive = csms_drive_t'({cfg.value[CFG_DRIVE_HI_BIT],
                                   cfg.value[CFG_DRIVE_LO_BIT]});
    next_st.gain = cfg.value[CFG_GAIN_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st <= TOP_RESET;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answer
  assign prdata_out = st.rd_data;
  assign pready_out = st.ack;
  assign pslverr_out = st.err && st.ack;

  // Pin and oscillator settings; a prohibited drive code is passed on
  // unchanged and flagged in the block status
  assign main_pin_mode_out = st.main_mode;
  assign sub_pin_mode_out = st.sub_mode;
  assign sub_drive_mode_out = st.drive;
  assign main_oscillator_high_gain_out = st.gain;
  assign config_locked_out = cfg.locked;

  // Clock source requests and settled status
  assign cpu_clock_source_select_out = st.cpu_select;
  assign cpu_clock_source_status_out = cpu_status;
  assign main_clock_source_select_out = st.main_select;
  assign main_clock_source_status_out = main_status;

endmodule

// >>> verilog/csms_config_once.sv
`timescale 1ns/100ps
module csms_config_once (
  input wire logic clk_in,
  input wire logic rst_n_in,
  csms_cfg_if.owner cfg
);
  import csms_pkg::*;

  typedef struct packed {
    logic [7:0] value;
    logic locked;
  } csms_once_state_t;

  csms_once_state_t st;
  csms_once_state_t next_st;

  // First write after reset lands, then the register freezes
  always_comb
  begin
    next_st = st;
    if (cfg.wr_en && !st.locked)
    begin
      next_st.value = cfg.wr_data & CFG_WRITABLE_MASK;
      next_st.locked = 1'b1;
    end
  end

  // Reset clears the value and re-arms the single write
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st <= '{value: CONFIG_RESET, locked: 1'b0};
    else
      st <= next_st;
  end

  assign cfg.value = st.value;
  assign cfg.locked = st.locked;
  assign cfg.late_write = cfg.wr_en && st.locked;
endmodule

// >>> verilog/csms_pkg.sv
package csms_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam logic [19:0] CONFIG_ADDR = 20'hfffa0;
  localparam logic [19:0] SELECT_ADDR = 20'hfffa4;
  localparam logic [19:0] STATUS_ADDR = 20'hfffa8;
  localparam logic [3:0] BYTE_LANE_ONLY = 4'h1;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MAIN_EXT_BIT = 7;
  localparam int unsigned CFG_MAIN_OSC_BIT = 6;
  localparam int unsigned CFG_SUB_EXT_BIT = 5;
  localparam int unsigned CFG_SUB_OSC_BIT = 4;
  localparam int unsigned CFG_DRIVE_HI_BIT = 2;
  localparam int unsigned CFG_DRIVE_LO_BIT = 1;
  localparam int unsigned CFG_GAIN_BIT = 0;
  localparam logic [7:0] CFG_WRITABLE_MASK = 8'hf7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int unsigned SEL_CPU_STATUS_BIT = 7;
  localparam int unsigned SEL_CPU_SELECT_BIT = 6;
  localparam int unsigned SEL_MAIN_STATUS_BIT = 5;
  localparam int unsigned SEL_MAIN_SELECT_BIT = 4;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam int unsigned ST_LOCKED_BIT = 0;
  localparam int unsigned ST_LATE_WRITE_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 2;
  localparam int unsigned ST_DRIVE_BAD_BIT = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SWITCH_SETTLE_NS = 40;
  localparam int unsigned SWITCH_SETTLE_CYCLES =
    (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSMS_PIN_INPUT_PORT,
    CSMS_PIN_OSCILLATOR,
    CSMS_PIN_EXTERNAL_CLOCK
  } csms_pin_mode_t;

  typedef enum logic [1:0] {
    CSMS_DRIVE_LOW_POWER,
    CSMS_DRIVE_NORMAL,
    CSMS_DRIVE_ULTRA_LOW,
    CSMS_DRIVE_PROHIBITED
  } csms_drive_t;

  // Pin-select pair to pin mode, shared by main and sub pins
  function automatic csms_pin_mode_t csms_decode_pin_mode(input logic ext_sel,
                                                          input logic osc_sel);
    csms_pin_mode_t mode;
    if (!osc_sel)
      mode = CSMS_PIN_INPUT_PORT;
    else if (ext_sel)
      mode = CSMS_PIN_EXTERNAL_CLOCK;
    else
      mode = CSMS_PIN_OSCILLATOR;
    return mode;
  endfunction

endpackage

// >>> verilog/csms_switch_tracker.sv
`timescale 1ns/100ps
module csms_switch_tracker #(
  parameter int unsigned SETTLE_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic select_in,
  input wire logic source_ready_in,
  output logic status_out,
  output logic busy_out
);
  import csms_pkg::*;

  localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

  typedef struct packed {
    logic status;
    logic [CW-1:0] count;
  } csms_trk_state_t;

  csms_trk_state_t st;
  csms_trk_state_t next_st;

  // Status moves only after the new source is ready and the settle time has run,
  // so a half-done switch never shows as done
  always_comb
  begin
    next_st = st;
    if (select_in != st.status && source_ready_in)
    begin
      if (st.count == LAST)
      begin
        next_st.status = select_in;
        next_st.count = '0;
      end
      else
        next_st.count = st.count + CW'(1);
    end
    else
      next_st.count = '0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st <= '{status: 1'b0, count: '0};
    else
      st <= next_st;
  end

  assign status_out = st.status;
  assign busy_out = select_in != st.status;
endmodule
